// ==== pkg/prp_pkg.sv ====
package prp_pkg;

    // ************************************************************
    // Clock and receive clock timing
    // ************************************************************
    localparam int CLK_HZ          = 100_000_000;
    localparam int RXCLK_FAST_HZ   = 25_000_000;
    localparam int RXCLK_SLOW_HZ   = 2_500_000;
    localparam int HALF_FAST_CYC   = CLK_HZ / (2 * RXCLK_FAST_HZ);
    localparam int HALF_SLOW_CYC   = CLK_HZ / (2 * RXCLK_SLOW_HZ);
    localparam int DIV_W           = 5;
    localparam logic [DIV_W-1:0] HALF_FAST_LAST = DIV_W'(HALF_FAST_CYC - 1);
    localparam logic [DIV_W-1:0] HALF_SLOW_LAST = DIV_W'(HALF_SLOW_CYC - 1);

    // Reduced interface at 10 Mb/s repeats each dibit over RPT_LAST + 1 ref edges
    localparam int RPT_W                    = 4;
    localparam logic [RPT_W-1:0] RPT_LAST   = 4'h9;

    // ************************************************************
    // Frame markers
    // ************************************************************
    localparam logic [3:0] SFD_HI_NIBBLE = 4'hD;

    // ************************************************************
    // Strap sample vector layout
    // ************************************************************
    localparam int STRAP_W         = 7;
    localparam int STRAP_MODE_B0   = 0;
    localparam int STRAP_MODE_B1   = 1;
    localparam int STRAP_RMII_SEL  = 2;
    localparam int STRAP_ADDR_B2   = 3;
    localparam int STRAP_ADDR_B0   = 4;
    localparam int STRAP_ADDR_B1   = 5;
    localparam int STRAP_MODE_B2   = 6;

    // ************************************************************
    // Pin drive patterns per interface
    // ************************************************************
    localparam logic [3:0] RXD_OE_MII  = 4'hF;
    localparam logic [3:0] RXD_OE_RMII = 4'h3;
    localparam logic [3:0] RXD_IDLE    = 4'h0;

    typedef enum logic [2:0] {
        PRP_ST_STRAP = 3'b001,
        PRP_ST_MII   = 3'b010,
        PRP_ST_RMII  = 3'b100
    } prp_state_t;

endpackage

// ==== design/prp_sync.sv ====
`timescale 1ns/1ps
module prp_sync
    import prp_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_q;

    // No reset: straps must flow through while reset is held
    always_comb begin
        next_q = q;
        for (int i = 0; i < W; i++) begin
            if (s2[i] == s3[i]) begin
                next_q[i] = s3[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        s1 <= d;
        s2 <= s1;
        s3 <= s2;
        q  <= next_q;
    end

endmodule // prp_sync

// ==== design/prp_rx_port.sv ====
`timescale 1ns/1ps
// Functional notes
// - MII four data lanes, RMII two lanes
// - Data bits 2 and 3 unused in RMII
// - Select strap low MII, high RMII
// - Management address from three address straps
// - Operating mode from three mode straps
// - Receive error flags errored frame data
// - Symbol mode (MII only): error pin carries code MSB
// - Otherwise shared pin is receive error
// - MII receive clock 25MHz or 2.5MHz
// - Data valid only while data presented
// - Straps captured at reset, used afterwards
// - RMII 10M: data low until SFD
module prp_rx_port
    import prp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Receive core side
    input  wire logic       core_valid,
    input  wire logic [3:0] core_nibble,
    input  wire logic       core_sym_msb,
    input  wire logic       core_err,
    input  wire logic       core_frame,
    input  wire logic       speed_100,
    input  wire logic       sym_mode,
    output logic            core_ready,
    // Captured configuration
    output logic [2:0]      op_mode,
    output logic [2:0]      mgmt_addr,
    output logic            rmii_sel,
    // Reference clock from the MAC side in reduced mode
    input  wire logic       ref_clk_in,
    // Shared receive / strap pins
    input  wire logic [3:0] rxd_in,
    output logic      [3:0] rxd_out,
    output logic      [3:0] rxd_oe,
    input  wire logic       rx_er_in,
    output logic            rx_er_out,
    output logic            rx_er_oe,
    input  wire logic       rx_clk_in,
    output logic            rx_clk_out,
    output logic            rx_clk_oe,
    input  wire logic       carrier_and_rx_valid_in,
    output logic            carrier_and_rx_valid_out,
    output logic            carrier_and_rx_valid_oe,
    output logic            rx_dv
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [STRAP_W-1:0] strap_pins;
    logic [STRAP_W-1:0] strap_sync;
    logic               ref_sync;
    // Ref clock runs free; a false edge after reset falls in strap state

    assign strap_pins = {carrier_and_rx_valid_in, rx_clk_in, rx_er_in, rxd_in};

    prp_sync #(.W(STRAP_W)) u_strap_sync (
        .clk (clk),
        .d   (strap_pins),
        .q   (strap_sync)
    );

    prp_sync #(.W(1)) u_ref_sync (
        .clk (clk),
        .d   (ref_clk_in),
        .q   (ref_sync)
    );

    // ************************************************************
    // Strap capture
    // ************************************************************
    logic [2:0] next_op_mode;
    logic [2:0] next_mgmt_addr;
    logic       next_rmii_sel;

    // Pins are released in reset, so the pulls set these levels
    // Sampled at every clock edge while reset is held; the last sample before release holds
    always_comb begin
        next_op_mode   = op_mode;
        next_mgmt_addr = mgmt_addr;
        next_rmii_sel  = rmii_sel;
        if (!rst_n) begin
            next_op_mode   = {strap_sync[STRAP_MODE_B2], strap_sync[STRAP_MODE_B1],
                              strap_sync[STRAP_MODE_B0]};
            next_mgmt_addr = {strap_sync[STRAP_ADDR_B2], strap_sync[STRAP_ADDR_B1],
                              strap_sync[STRAP_ADDR_B0]};
            next_rmii_sel  = strap_sync[STRAP_RMII_SEL];
        end
    end

    always_ff @(posedge clk) begin
        op_mode   <= next_op_mode;
        mgmt_addr <= next_mgmt_addr;
        rmii_sel  <= next_rmii_sel;
    end

    // ************************************************************
    // Receive path state
    // ************************************************************
    prp_state_t       state;
    prp_state_t       next_state;
    logic [DIV_W-1:0] div_cnt;
    logic [DIV_W-1:0] next_div_cnt;
    logic [RPT_W-1:0] rpt_cnt;
    logic [RPT_W-1:0] next_rpt_cnt;
    logic             ref_prev;
    logic             hold_valid;
    logic             next_hold_valid;
    logic [3:0]       hold_nib;
    logic [3:0]       next_hold_nib;
    logic             hold_msb;
    logic             next_hold_msb;
    logic             hold_err;
    logic             next_hold_err;
    logic             phase;
    logic             next_phase;
    logic             sfd_seen;
    logic             next_sfd_seen;
    logic             next_core_ready;
    logic [3:0]       next_rxd_out;
    logic [3:0]       next_rxd_oe;
    logic             next_rx_er_out;
    logic             next_rx_er_oe;
    logic             next_rx_clk_out;
    logic             next_rx_clk_oe;
    logic             next_crs_out;
    logic             next_crs_oe;
    logic             next_rx_dv;
    logic [DIV_W-1:0] half_last;
    logic             ref_rise;
    logic             rmii_tick;
    logic             gate_low;

    always_comb begin
        next_state      = state;
        next_div_cnt    = div_cnt;
        next_rpt_cnt    = rpt_cnt;
        next_hold_valid = hold_valid;
        next_hold_nib   = hold_nib;
        next_hold_msb   = hold_msb;
        next_hold_err   = hold_err;
        next_phase      = phase;
        next_sfd_seen   = sfd_seen;
        next_rxd_out    = rxd_out;
        next_rxd_oe     = rxd_oe;
        next_rx_er_out  = rx_er_out;
        next_rx_er_oe   = rx_er_oe;
        next_rx_clk_out = rx_clk_out;
        next_rx_clk_oe  = rx_clk_oe;
        next_crs_out    = carrier_and_rx_valid_out;
        next_crs_oe     = carrier_and_rx_valid_oe;
        next_rx_dv      = rx_dv;
        half_last       = speed_100 ? HALF_FAST_LAST : HALF_SLOW_LAST;
        ref_rise        = ref_sync && !ref_prev;
        rmii_tick       = ref_rise && (speed_100 || rpt_cnt == RPT_LAST);
        gate_low        = !speed_100 && !sfd_seen;

        case (state)
            PRP_ST_STRAP: begin
                // Drive starts only the cycle after release
                if (rmii_sel) begin
                    next_state  = PRP_ST_RMII;
                    next_rxd_oe = RXD_OE_RMII;
                    next_crs_oe = 1'b1;
                end else begin
                    next_state     = PRP_ST_MII;
                    next_rxd_oe    = RXD_OE_MII;
                    next_rx_clk_oe = 1'b1;
                end
                next_rx_er_oe = 1'b1;
            end
            PRP_ST_MII: begin
                if (div_cnt >= half_last) begin
                    next_div_cnt    = '0;
                    next_rx_clk_out = !rx_clk_out;
                    // Update at the falling edge so the MAC samples at the rising one
                    if (rx_clk_out) begin
                        if (hold_valid) begin
                            next_rxd_out    = hold_nib;
                            next_rx_dv      = 1'b1;
                            next_rx_er_out  = sym_mode ? hold_msb
                                                       : hold_err;
                            next_hold_valid = 1'b0;
                        end else begin
                            next_rxd_out   = RXD_IDLE;
                            next_rx_dv     = 1'b0;
                            next_rx_er_out = 1'b0;
                        end
                    end
                end else begin
                    next_div_cnt = div_cnt + 1'b1;
                end
            end
            PRP_ST_RMII: begin
                // Slow rate holds each dibit across several ref edges
                if (ref_rise) begin
                    if (speed_100 || rpt_cnt == RPT_LAST) begin
                        next_rpt_cnt = '0;
                    end else begin
                        next_rpt_cnt = rpt_cnt + 1'b1;
                    end
                end
                if (rmii_tick) begin
                    next_crs_out = core_frame || hold_valid;
                    // Lanes 3:2 stay released in this mode
                    next_rxd_out[3:2] = 2'b00;
                    if (!phase) begin
                        if (hold_valid) begin
                            if (!speed_100 && hold_nib == SFD_HI_NIBBLE) begin
                                next_sfd_seen = 1'b1;
                            end
                            if (gate_low && hold_nib != SFD_HI_NIBBLE) begin
                                next_rxd_out[1:0] = 2'b00;
                            end else begin
                                next_rxd_out[1:0] = hold_nib[1:0];
                            end
                            next_rx_er_out = hold_err;
                            next_phase     = 1'b1;
                        end else begin
                            next_rxd_out[1:0] = 2'b00;
                            next_rx_er_out    = 1'b0;
                        end
                    end else begin
                        next_rxd_out[1:0] = gate_low ? 2'b00
                                                     : hold_nib[3:2];
                        next_phase        = 1'b0;
                        next_hold_valid   = 1'b0;
                    end
                    if (!core_frame && !hold_valid) begin
                        next_sfd_seen = 1'b0;
                    end
                end
            end
            default: begin
                next_state = PRP_ST_STRAP;
            end
        endcase

        // Single slot; the core stalls until the pins drain it
        if (core_valid && core_ready) begin
            next_hold_valid = 1'b1;
            next_hold_nib   = core_nibble;
            next_hold_msb   = core_sym_msb;
            next_hold_err   = core_err;
        end
        next_core_ready = !next_hold_valid && (state != PRP_ST_STRAP);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state                    <= PRP_ST_STRAP;
            div_cnt                  <= '0;
            rpt_cnt                  <= '0;
            ref_prev                 <= 1'b0;
            hold_valid               <= 1'b0;
            hold_nib                 <= 4'h0;
            hold_msb                 <= 1'b0;
            hold_err                 <= 1'b0;
            phase                    <= 1'b0;
            sfd_seen                 <= 1'b0;
            core_ready               <= 1'b0;
            rxd_out                  <= RXD_IDLE;
            rxd_oe                   <= 4'h0;
            rx_er_out                <= 1'b0;
            rx_er_oe                 <= 1'b0;
            rx_clk_out               <= 1'b0;
            rx_clk_oe                <= 1'b0;
            carrier_and_rx_valid_out <= 1'b0;
            carrier_and_rx_valid_oe  <= 1'b0;
            rx_dv                    <= 1'b0;
        end else begin
            state                    <= next_state;
            div_cnt                  <= next_div_cnt;
            rpt_cnt                  <= next_rpt_cnt;
            ref_prev                 <= ref_sync;
            hold_valid               <= next_hold_valid;
            hold_nib                 <= next_hold_nib;
            hold_msb                 <= next_hold_msb;
            hold_err                 <= next_hold_err;
            phase                    <= next_phase;
            sfd_seen                 <= next_sfd_seen;
            core_ready               <= next_core_ready;
            rxd_out                  <= next_rxd_out;
            rxd_oe                   <= next_rxd_oe;
            rx_er_out                <= next_rx_er_out;
            rx_er_oe                 <= next_rx_er_oe;
            rx_clk_out               <= next_rx_clk_out;
            rx_clk_oe                <= next_rx_clk_oe;
            carrier_and_rx_valid_out <= next_crs_out;
            carrier_and_rx_valid_oe  <= next_crs_oe;
            rx_dv                    <= next_rx_dv;
        end
    end

endmodule // prp_rx_port

// ==== tb/prp_rx_port_monitor.sv ====
`timescale 1ns/1ps
module prp_rx_port_monitor
    import prp_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       speed_100,
    input wire logic       rmii_sel,
    input wire logic [2:0] op_mode,
    input wire logic [2:0] mgmt_addr,
    input wire logic [3:0] rxd_out,
    input wire logic [3:0] rxd_oe,
    input wire logic       rx_er_out,
    input wire logic       rx_er_oe,
    input wire logic       rx_clk_out,
    input wire logic       rx_clk_oe,
    input wire logic       carrier_and_rx_valid_oe,
    input wire logic       rx_dv
);
    // ************************************************************
    // Receive clock run length, age of the speed setting
    // ************************************************************
    logic [5:0] run_len;
    logic [5:0] next_run_len;
    logic [5:0] spd_age;
    logic [5:0] next_spd_age;
    logic       clk_q;
    logic       spd_q;

    always_comb begin
        next_run_len = (rx_clk_out != clk_q) ? 6'h01 : run_len + 6'h01;
        next_spd_age = (speed_100 != spd_q) ? 6'h00 : spd_age + {5'h00, spd_age != 6'h3F};
    end

    always_ff @(posedge clk) begin
        clk_q   <= rx_clk_out;
        spd_q   <= speed_100;
        run_len <= rst_n ? next_run_len : 6'h00;
        spd_age <= rst_n ? next_spd_age : 6'h00;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_oe_reset: assert property (disable iff (1'b0)
        !rst_n |=> (rxd_oe == 4'h0) && !rx_clk_oe && !carrier_and_rx_valid_oe)
        else $error("receive pins driven in reset");
    chk_oe_release: assert property ($rose(rst_n) |->
        ##2 ((rxd_oe == (rmii_sel ? RXD_OE_RMII : RXD_OE_MII)) && (rx_clk_oe == !rmii_sel)
        && rx_er_oe && (carrier_and_rx_valid_oe == rmii_sel)))
        else $error("pin drive wrong after reset");
    chk_mii_lanes: assert property (!rmii_sel && (rxd_oe != 4'h0) |-> rxd_oe == RXD_OE_MII)
        else $error("mii lanes not all driven");
    chk_rmii_lanes: assert property (rmii_sel |->
        (rxd_oe[3:2] == 2'h0) && (rxd_out[3:2] == 2'h0) && !rx_clk_oe)
        else $error("upper lanes used in reduced mode");
    chk_pin_sync: assert property (!rmii_sel &&
        ($changed(rxd_out) || $changed(rx_dv) || $changed(rx_er_out)) |-> $fell(rx_clk_out))
        else $error("receive pins change off clock fall");
    chk_idle_zero: assert property (!rmii_sel && !rx_dv |-> rxd_out == RXD_IDLE && !rx_er_out)
        else $error("data shown without valid");
    chk_clk_half: assert property (!rmii_sel && rx_clk_oe && (rx_clk_out != clk_q)
        && (spd_age > 6'h2C) |-> run_len == (speed_100 ? 6'(HALF_FAST_CYC) : 6'(HALF_SLOW_CYC)))
        else $error("receive clock half period wrong");
    chk_strap_hold: assert property ($past(rst_n) |->
        $stable(op_mode) && $stable(mgmt_addr) && $stable(rmii_sel))
        else $error("strap values moved after reset");
endmodule // prp_rx_port_monitor

bind prp_rx_port prp_rx_port_monitor u_mon (
    .clk(clk), .rst_n(rst_n), .speed_100(speed_100), .rmii_sel(rmii_sel),
    .op_mode(op_mode), .mgmt_addr(mgmt_addr), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
    .rx_er_out(rx_er_out), .rx_er_oe(rx_er_oe), .rx_clk_out(rx_clk_out), .rx_clk_oe(rx_clk_oe),
    .carrier_and_rx_valid_oe(carrier_and_rx_valid_oe), .rx_dv(rx_dv)
);

// ==== tb/prp_mac_model.sv ====
`timescale 1ns/1ps
module prp_mac_model (
    input  wire logic [6:0] strap,
    input  wire logic [3:0] rxd_out,
    input  wire logic [3:0] rxd_oe,
    input  wire logic       rx_er_out,
    input  wire logic       rx_er_oe,
    input  wire logic       rx_clk_out,
    input  wire logic       rx_clk_oe,
    input  wire logic       crs_out,
    input  wire logic       crs_oe,
    input  wire logic       rx_dv,
    input  wire logic       rmii,
    output logic      [3:0] rxd_in,
    output logic            rx_er_in,
    output logic            rx_clk_in,
    output logic            crs_in,
    output logic            ref_clk
);
    logic [4:0] q[$];

    // Board pulls win wherever the port lets go
    always_comb begin
        for (int i = 0; i < 4; i++) rxd_in[i] = rxd_oe[i] ? rxd_out[i] : strap[i];
        rx_er_in  = rx_er_oe ? rx_er_out : strap[4];
        rx_clk_in = rx_clk_oe ? rx_clk_out : strap[5];
        crs_in    = crs_oe ? crs_out : strap[6];
    end

    // Free-running reference, phase unrelated to clk
    initial begin
        ref_clk = 1'b0;
        #3.3;
        forever #80 ref_clk = ~ref_clk;
    end

    always @(posedge rx_clk_in) if (!rmii && rx_dv) q.push_back({rx_er_in, rxd_in});

    // Error pin ignored in reduced mode
    always @(posedge ref_clk) if (rmii && crs_in) q.push_back({3'h0, rxd_in[1:0]});
endmodule // prp_mac_model

// ==== tb/prp_rx_port_tb.sv ====
`timescale 1ns/1ps
module prp_rx_port_tb;
    logic clk, rst_n, core_valid, core_sym_msb, core_err, core_frame, speed_100, sym_mode;
    logic [3:0] core_nibble;
    logic [6:0] strap;
    logic core_ready, rmii_sel, rx_er_in, rx_er_out, rx_er_oe, rx_clk_in, rx_clk_out, rx_clk_oe;
    logic crs_in, crs_out, crs_oe, rx_dv, ref_clk;
    logic [2:0] op_mode, mgmt_addr;
    logic [3:0] rxd_in, rxd_out, rxd_oe;
    int failures = 0;
    int n_tests = 0;

    prp_rx_port u_dut (.clk(clk), .rst_n(rst_n), .core_valid(core_valid),
        .core_nibble(core_nibble), .core_sym_msb(core_sym_msb), .core_err(core_err),
        .core_frame(core_frame), .speed_100(speed_100), .sym_mode(sym_mode),
        .core_ready(core_ready), .op_mode(op_mode), .mgmt_addr(mgmt_addr),
        .rmii_sel(rmii_sel), .ref_clk_in(ref_clk), .rxd_in(rxd_in), .rxd_out(rxd_out),
        .rxd_oe(rxd_oe), .rx_er_in(rx_er_in), .rx_er_out(rx_er_out), .rx_er_oe(rx_er_oe),
        .rx_clk_in(rx_clk_in), .rx_clk_out(rx_clk_out), .rx_clk_oe(rx_clk_oe),
        .carrier_and_rx_valid_in(crs_in), .carrier_and_rx_valid_out(crs_out),
        .carrier_and_rx_valid_oe(crs_oe), .rx_dv(rx_dv));

    prp_mac_model u_mac (.strap(strap), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
        .rx_er_out(rx_er_out), .rx_er_oe(rx_er_oe), .rx_clk_out(rx_clk_out),
        .rx_clk_oe(rx_clk_oe), .crs_out(crs_out), .crs_oe(crs_oe), .rx_dv(rx_dv),
        .rmii(rmii_sel), .rxd_in(rxd_in), .rx_er_in(rx_er_in), .rx_clk_in(rx_clk_in),
        .crs_in(crs_in), .ref_clk(ref_clk));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    function automatic int first_nz();
        for (int j = 0; j < u_mac.q.size(); j++) if (u_mac.q[j] != 5'h00) return j;
        return -1;
    endfunction

    task automatic wait_data(input int n, output int f);
        f = -1;
        for (int i = 0; i < 8000 && !(f >= 0 && u_mac.q.size() >= f + n); i++) begin
            @(negedge clk);
            f = first_nz();
        end
        if (f < 0 || u_mac.q.size() < f + n) begin
            failures++;
            $display("[FAIL] receive data expected %0d seen %0d", n, u_mac.q.size());
            report_and_stop();
        end
    endtask

    task automatic do_reset(input logic [2:0] m, input logic [2:0] a, input logic r,
                            input logic spd);
        strap = {m[2], a[1], a[0], a[2], r, m[1], m[0]};
        speed_100 = spd;
        rst_n = 1'b0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        u_mac.q.delete();
    endtask

    task automatic send(input logic [3:0] n, input logic m, input logic e);
        for (int i = 0; i < 1000 && core_ready !== 1'b1; i++) @(negedge clk);
        chk("core_ready", 8'(core_ready), 8'h01);
        if (core_ready !== 1'b1) report_and_stop();
        core_valid = 1'b1;
        core_nibble = n;
        core_sym_msb = m;
        core_err = e;
        @(negedge clk);
        core_valid = 1'b0;
    endtask

    task automatic t_straps();
        do_reset(3'h7, 3'h0, 1'b0, 1'b1);
        chk("op_mode default", 8'(op_mode), 8'h07);
        chk("mgmt_addr default", 8'(mgmt_addr), 8'h00);
        chk("rmii_sel default", 8'(rmii_sel), 8'h00);
        do_reset(3'h2, 3'h4, 1'b1, 1'b1);
        chk("op_mode strapped", 8'(op_mode), 8'h02);
        chk("mgmt_addr strapped", 8'(mgmt_addr), 8'h04);
        chk("rmii_sel strapped", 8'(rmii_sel), 8'h01);
        $display("test straps done");
    endtask

    task automatic t_mii(input logic spd, input logic sym);
        int f;
        logic [3:0] nb;
        sym_mode = sym;
        do_reset(3'h7, 3'h0, 1'b0, spd);
        core_frame = 1'b1;
        for (int k = 0; k < 3; k++) send(4'h9 + 4'(k * 5), k != 1, k == 1);
        wait_data(3, f);
        for (int k = 0; k < 3; k++) begin
            nb = 4'h9 + 4'(k * 5);
            chk("mii nibble", 8'(u_mac.q[k][3:0]), 8'(nb));
            chk("mii rx_er", 8'(u_mac.q[k][4]), 8'(sym ? k != 1 : k == 1));
        end
        repeat (100) @(negedge clk);
        chk("mii nibble count", 8'(u_mac.q.size()), 8'h03);
        core_frame = 1'b0;
        $display("test mii speed %0d symbol %0d done", spd, sym);
    endtask

    task automatic t_rmii_fast();
        int f;
        do_reset(3'h7, 3'h0, 1'b1, 1'b1);
        core_frame = 1'b1;
        send(4'h6, 1'b0, 1'b0);
        send(4'h9, 1'b0, 1'b1);
        wait_data(4, f);
        chk("rmii dibits", {u_mac.q[f][1:0], u_mac.q[f+1][1:0], u_mac.q[f+2][1:0],
            u_mac.q[f+3][1:0]}, 8'h96);
        core_frame = 1'b0;
        $display("test rmii fast done");
    endtask

    task automatic t_rmii_slow();
        int f;
        int n;
        do_reset(3'h7, 3'h0, 1'b1, 1'b0);
        core_frame = 1'b1;
        send(4'h5, 1'b0, 1'b0);
        send(4'h5, 1'b0, 1'b0);
        send(4'hD, 1'b0, 1'b0);
        send(4'hA, 1'b0, 1'b0);
        wait_data(30, f);
        n = f;
        while (n < f + 29 && u_mac.q[n] == 5'h01) n++;
        chk("sfd first dibit", 8'(u_mac.q[f]), 8'h01);
        chk("sfd dibit run", 8'(n - f <= 11), 8'h01);
        chk("sfd second dibit", 8'(u_mac.q[n]), 8'h03);
        core_frame = 1'b0;
        $display("test rmii slow done");
    endtask

    initial begin
        rst_n = 1'b0;
        core_valid = 1'b0;
        core_nibble = 4'h0;
        core_sym_msb = 1'b0;
        core_err = 1'b0;
        core_frame = 1'b0;
        speed_100 = 1'b1;
        sym_mode = 1'b0;
        strap = 7'h43;
        t_straps();
        t_mii(1'b1, 1'b0);
        t_mii(1'b1, 1'b1);
        t_mii(1'b0, 1'b0);
        t_rmii_fast();
        t_rmii_slow();
        report_and_stop();
    end
endmodule // prp_rx_port_tb
